// ==== verilog/pcm_pkg.sv ====
// constants for the power and clock manager
// assumes one 10 mhz bus clock and byte addresses on the register bus
package pcm_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_SC_EN = 8'h00;
   localparam logic [7:0] ADDR_SC_DIS = 8'h04;
   localparam logic [7:0] ADDR_SC_STAT = 8'h08;
   localparam logic [7:0] ADDR_PC_EN = 8'h10;
   localparam logic [7:0] ADDR_PC_DIS = 8'h14;
   localparam logic [7:0] ADDR_PC_STAT = 8'h18;
   localparam logic [7:0] ADDR_MOR = 8'h20;
   localparam logic [7:0] ADDR_MFR = 8'h24;
   localparam logic [7:0] ADDR_PLL = 8'h2c;
   localparam logic [7:0] ADDR_MCK = 8'h30;
   localparam logic [7:0] ADDR_PCK0 = 8'h40;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h60;
   localparam logic [7:0] ADDR_IRQ_DIS = 8'h64;
   localparam logic [7:0] ADDR_SR = 8'h68;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h6c;
   localparam int PCK_COUNT = 3;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SC_PROC = 0;
   localparam int SC_USB = 7;
   localparam int SC_PCK0 = 8;
   localparam int SR_OSC = 0;
   localparam int SR_LOCK = 2;
   localparam int SR_MCK = 3;
   localparam int SR_PCK0 = 8;
   localparam int MOR_EN = 0;
   localparam int MOR_BYP = 1;
   localparam int MOR_CNT = 8;
   localparam int MFR_RDY = 16;
   localparam int PLL_DIV = 0;
   localparam int PLL_CNT = 8;
   localparam int PLL_OUT = 14;
   localparam int PLL_MUL = 16;
   localparam int PLL_USB = 28;
   localparam int CFG_CLOCK_PRESCALER = 2;
   // ----------------------------------------
   // encodings, reset values and counts
   // ----------------------------------------
   localparam logic [1:0] CSS_SLOW = 2'h0;
   localparam logic [1:0] CSS_MAIN = 2'h1;
   localparam logic [1:0] CSS_PLL = 2'h3;
   localparam logic [7:0] RST_DIV = 8'h00;
   localparam logic [10:0] RST_MUL = 11'h000;
   localparam logic [1:0] RST_CSS = 2'h0;
   localparam logic [2:0] RST_CLOCK_PRESCALER = 3'h0;
   localparam logic [2:0] CLOCK_PRESCALER_MAX = 3'h6;
   localparam logic [2:0] OSC_TICK_LAST = 3'h7;
   localparam logic [4:0] MEAS_SLOW = 5'h10;
endpackage

// ==== verilog/pcm_prescaler.sv ====
// power-of-two clock prescaler with a ready flag
// assumes the source is a filtered level on the bus clock
`timescale 1ns/1ns
module pcm_prescaler
   import pcm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic src_level,
   input wire logic [2:0] clock_prescaler,
   input wire logic enable,
   input wire logic load,
   output logic clk_out,
   output logic ready
);
   logic prev_reg;
   logic [5:0] cnt_reg;
   logic out_reg;
   logic ready_reg;
   wire rise = src_level & ~prev_reg;
   wire restart = load | ~enable;
   // reserved code 7 runs as divide by 64
   wire [2:0] idx = (clock_prescaler > CLOCK_PRESCALER_MAX) ? 3'h5 : clock_prescaler - 3'h1;
   wire divided = (clock_prescaler == 3'h0) ? src_level : cnt_reg[idx];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prev_reg <= 1'b0;
         cnt_reg <= 6'h00;
         out_reg <= 1'b0;
         ready_reg <= 1'b0;
      end
      else
      begin
         prev_reg <= src_level;
         cnt_reg <= restart ? 6'h00 : cnt_reg + {5'h00, rise};
         out_reg <= enable & divided;
         ready_reg <= ~restart & (ready_reg | rise);
      end
   end
   assign clk_out = out_reg;
   assign ready = ready_reg;
endmodule

// ==== verilog/pcm_freq_meter.sv ====
// main clock frequency counter from a slow rise to the sixteenth slow fall
// assumes filtered levels of both clocks on the bus clock
`timescale 1ns/1ns
module pcm_freq_meter
   import pcm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic slow_level,
   input wire logic main_level,
   input wire logic stable,
   output logic [15:0] count,
   output logic ready
);
   typedef enum logic [1:0] {st_idle, st_wait, st_count, st_done} pcm_meas_t;
   pcm_meas_t state_reg;
   logic slow_prev_reg;
   logic main_prev_reg;
   logic [4:0] falls_reg;
   logic [15:0] count_reg;
   wire slow_rise = slow_level & ~slow_prev_reg;
   wire slow_fall = ~slow_level & slow_prev_reg;
   wire main_rise = main_level & ~main_prev_reg;
   wire last_fall = slow_fall & (falls_reg == MEAS_SLOW - 5'h01);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= st_idle;
         slow_prev_reg <= 1'b0;
         main_prev_reg <= 1'b0;
         falls_reg <= 5'h00;
         count_reg <= 16'h0000;
      end
      else
      begin
         slow_prev_reg <= slow_level;
         main_prev_reg <= main_level;
         case (state_reg)
            st_idle:
               if (stable)
               begin
                  state_reg <= st_wait;
                  falls_reg <= 5'h00;
                  count_reg <= 16'h0000;
               end
            st_wait:
               if (slow_rise)
                  state_reg <= st_count;
            st_count:
            begin
               count_reg <= count_reg + {15'h0000, main_rise};
               falls_reg <= falls_reg + {4'h0, slow_fall};
               if (last_fall)
                  state_reg <= st_done;
            end
            default:
               state_reg <= st_done;
         endcase
         // a lost oscillator aborts and rearms the measurement
         if (!stable)
            state_reg <= st_idle;
      end
   end
   assign count = count_reg;
   assign ready = (state_reg == st_done);
endmodule

// ==== verilog/pcm_top.sv ====
// power and clock manager: oscillator, pll control, master clock,
// idle mode, usb, peripheral and programmable clock gating
// assumes an ahb-lite master and clock pins slower than hclk / 4
//
// Contract
// - divider takes 1..255; zero holds divider and pll output low
// - reset clears every divider setting so the pll gets no input
// - pll output is source times (multiplier + 1) over divider
// - multiplier zero powers the pll down, nonzero re-enables it
// - pll change clears lock, loads count, counts slow clock to lock
// - usb clock is pll output divided by 1, 2 or 4; code 3 divides by 8
// - master clock picks slow, main or pll, divided by 1 to 64
// - master clock write clears ready until the new clock runs
// - processor clock on after reset, stopped by write, woken by irq
// - processor clock stops only after current instruction ends
// - usb clock enabled, disabled and shown by system clock registers
// - peripheral clocks set and cleared by ones, stop now, reset off
// - peripheral bit position equals the peripheral identifier
// - three programmable outputs each pick a source and 1 to 64
// - programmable outputs enabled, disabled and shown by ones
// - each programmable output has a ready flag once it runs
// - measurement sets ready and reports main cycles per 16 slow; counts from a slow rise to the 16th slow fall
// - oscillator enable clears stable, counts slow / 8, then sets
// - after reset oscillator off and slow clock selected
`timescale 1ns/1ns
module pcm_top
   import pcm_pkg::*;
#(
   parameter int PERIPH_COUNT = 32
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic slow_clock,
   input wire logic main_clock,
   input wire logic pll_clock,
   input wire logic wake_fast_irq,
   input wire logic wake_normal_irq,
   input wire logic instruction_done,
   output logic main_oscillator_enable,
   output logic oscillator_bypass,
   output logic [7:0] pll_divider,
   output logic [10:0] pll_multiplier,
   output logic [1:0] pll_out_range,
   output logic pll_enable,
   output logic master_clock,
   output logic processor_clock_enable,
   output logic usb_device_clock,
   output logic [PERIPH_COUNT-1:0] peripheral_clock_enable,
   output logic [PCK_COUNT-1:0] programmable_clock_output,
   output logic clock_irq
);
   // ----------------------------------------
   // source selection
   // ----------------------------------------
   function automatic logic pick(input logic [1:0] clock_source_select,
      input logic slow, input logic main, input logic pll);
      pick = (clock_source_select == CSS_MAIN) ? main : (clock_source_select == CSS_PLL) ? pll : slow;
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // a level moves only when stages two and three agree
   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [2:0] s3_reg;
   logic [2:0] lvl_reg;
   logic slow_prev_reg;
   wire [2:0] pin_in = {pll_clock, main_clock, slow_clock};
   wire [2:0] lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s1_reg <= 3'h0;
         s2_reg <= 3'h0;
         s3_reg <= 3'h0;
         lvl_reg <= 3'h0;
         slow_prev_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
         slow_prev_reg <= lvl_reg[0];
      end
   end
   wire slow_lvl = lvl_reg[0];
   wire main_lvl = lvl_reg[1];
   wire slow_rise = slow_lvl & ~slow_prev_reg;

   // ----------------------------------------
   // ahb-lite slave
   // ----------------------------------------
   // zero wait states; reads are sampled in the address phase
   logic wr_pend_reg;
   logic [7:0] waddr_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rmux;
   wire take = hsel & hready & htrans[1];
   wire wr_stb = wr_pend_reg;
   wire w_sc_en = wr_stb & (waddr_reg == ADDR_SC_EN);
   wire w_sc_dis = wr_stb & (waddr_reg == ADDR_SC_DIS);
   wire w_pc_en = wr_stb & (waddr_reg == ADDR_PC_EN);
   wire w_pc_dis = wr_stb & (waddr_reg == ADDR_PC_DIS);
   wire w_mor = wr_stb & (waddr_reg == ADDR_MOR);
   wire w_pll = wr_stb & (waddr_reg == ADDR_PLL);
   wire w_mck = wr_stb & (waddr_reg == ADDR_MCK);
   wire w_irq_en = wr_stb & (waddr_reg == ADDR_IRQ_EN);
   wire w_irq_dis = wr_stb & (waddr_reg == ADDR_IRQ_DIS);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         waddr_reg <= 8'h00;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_reg <= take & hwrite;
         waddr_reg <= haddr[7:0];
         if (take & ~hwrite)
            rdata_reg <= rmux;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   // ----------------------------------------
   // main oscillator
   // ----------------------------------------
   logic mosc_en_reg;
   logic bypass_reg;
   logic [7:0] osc_cnt_reg;
   logic [7:0] osc_down_reg;
   logic [2:0] osc_tick_reg;
   logic osc_stable_reg;
   wire osc_tick = slow_rise & (osc_tick_reg == OSC_TICK_LAST);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mosc_en_reg <= 1'b0;
         bypass_reg <= 1'b0;
         osc_cnt_reg <= 8'h00;
         osc_down_reg <= 8'h00;
         osc_tick_reg <= 3'h0;
         osc_stable_reg <= 1'b0;
      end
      else if (w_mor)
      begin
         mosc_en_reg <= hwdata[MOR_EN];
         bypass_reg <= hwdata[MOR_BYP];
         osc_cnt_reg <= hwdata[MOR_CNT +: 8];
         osc_down_reg <= hwdata[MOR_CNT +: 8];
         osc_tick_reg <= 3'h0;
         osc_stable_reg <= 1'b0;
      end
      else
      begin
         osc_tick_reg <= osc_tick_reg + {2'h0, slow_rise};
         if (osc_tick & mosc_en_reg & ~osc_stable_reg)
         begin
            osc_down_reg <= osc_down_reg - {7'h00, |osc_down_reg};
            osc_stable_reg <= (osc_down_reg <= 8'h01);
         end
      end
   end
   assign main_oscillator_enable = mosc_en_reg;
   assign oscillator_bypass = bypass_reg;

   // ----------------------------------------
   // frequency measurement
   // ----------------------------------------
   logic [15:0] meas_count;
   logic meas_ready;
   pcm_freq_meter u_meter (
      .hclk(hclk),
      .hresetn(hresetn),
      .slow_level(slow_lvl),
      .main_level(main_lvl),
      .stable(osc_stable_reg),
      .count(meas_count),
      .ready(meas_ready)
   );

   // ----------------------------------------
   // pll control and lock counter
   // ----------------------------------------
   logic [7:0] div_reg;
   logic [5:0] lock_cnt_reg;
   logic [1:0] out_rng_reg;
   logic [10:0] mul_reg;
   logic [1:0] usb_div_reg;
   logic [5:0] lock_down_reg;
   logic lock_reg;
   wire pll_on = (mul_reg != RST_MUL) & (div_reg != RST_DIV);
   // a stopped divider or pll gives a constant low clock
   wire pll_lvl = lvl_reg[2] & pll_on;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_reg <= RST_DIV;
         lock_cnt_reg <= 6'h00;
         out_rng_reg <= 2'h0;
         mul_reg <= RST_MUL;
         usb_div_reg <= 2'h0;
         lock_down_reg <= 6'h00;
         lock_reg <= 1'b0;
      end
      else if (w_pll)
      begin
         div_reg <= hwdata[PLL_DIV +: 8];
         lock_cnt_reg <= hwdata[PLL_CNT +: 6];
         out_rng_reg <= hwdata[PLL_OUT +: 2];
         mul_reg <= hwdata[PLL_MUL +: 11];
         usb_div_reg <= hwdata[PLL_USB +: 2];
         lock_down_reg <= hwdata[PLL_CNT +: 6];
         lock_reg <= 1'b0;
      end
      else if (slow_rise & pll_on & ~lock_reg)
      begin
         lock_down_reg <= lock_down_reg - {5'h00, |lock_down_reg};
         lock_reg <= (lock_down_reg <= 6'h01);
      end
   end
   // the analog pll multiplies by (mul + 1) / div
   assign pll_divider = div_reg;
   assign pll_multiplier = mul_reg;
   assign pll_out_range = out_rng_reg;
   assign pll_enable = mul_reg != RST_MUL;

   // ----------------------------------------
   // master clock
   // ----------------------------------------
   logic [1:0] mck_css_reg;
   logic [2:0] mck_clock_prescaler_reg;
   logic mck_presc_rdy;
   // while the pll relocks the master clock runs from main clock
   wire pll_wait = (mck_css_reg == CSS_PLL) & ~lock_reg;
   wire [1:0] mck_css_eff = pll_wait ? CSS_MAIN : mck_css_reg;
   wire mck_src = pick(mck_css_eff, slow_lvl, main_lvl, pll_lvl);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mck_css_reg <= RST_CSS;
         mck_clock_prescaler_reg <= RST_CLOCK_PRESCALER;
      end
      else if (w_mck)
      begin
         mck_css_reg <= hwdata[1:0];
         mck_clock_prescaler_reg <= hwdata[CFG_CLOCK_PRESCALER +: 3];
      end
   end
   pcm_prescaler u_mck (
      .hclk(hclk),
      .hresetn(hresetn),
      .src_level(mck_src),
      .clock_prescaler(mck_clock_prescaler_reg),
      .enable(1'b1),
      .load(w_mck | w_pll),
      .clk_out(master_clock),
      .ready(mck_presc_rdy)
   );
   wire mck_ready = mck_presc_rdy & ~pll_wait;

   // ----------------------------------------
   // system clocks: processor, usb, outputs
   // ----------------------------------------
   logic proc_en_reg;
   logic stop_pend_reg;
   logic usb_en_reg;
   logic [PCK_COUNT-1:0] pck_en_reg;
   wire wake = wake_fast_irq | wake_normal_irq;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         proc_en_reg <= 1'b1;
         stop_pend_reg <= 1'b0;
         usb_en_reg <= 1'b0;
         pck_en_reg <= '0;
      end
      else
      begin
         // a wake or enable always beats a pending stop
         if (wake | (w_sc_en & hwdata[SC_PROC]))
         begin
            proc_en_reg <= 1'b1;
            stop_pend_reg <= 1'b0;
         end
         else if (w_sc_dis & hwdata[SC_PROC])
            stop_pend_reg <= 1'b1;
         else if (stop_pend_reg & instruction_done)
         begin
            proc_en_reg <= 1'b0;
            stop_pend_reg <= 1'b0;
         end
         if (w_sc_en & hwdata[SC_USB])
            usb_en_reg <= 1'b1;
         else if (w_sc_dis & hwdata[SC_USB])
            usb_en_reg <= 1'b0;
         if (w_sc_en | w_sc_dis)
            pck_en_reg <= (pck_en_reg
               | ({PCK_COUNT{w_sc_en}} & hwdata[SC_PCK0 +: PCK_COUNT]))
               & ~({PCK_COUNT{w_sc_dis}} & hwdata[SC_PCK0 +: PCK_COUNT]);
      end
   end
   assign processor_clock_enable = proc_en_reg;

   pcm_prescaler u_usb (
      .hclk(hclk),
      .hresetn(hresetn),
      .src_level(pll_lvl),
      .clock_prescaler({1'b0, usb_div_reg}),
      .enable(usb_en_reg),
      .load(w_pll),
      .clk_out(usb_device_clock),
      .ready()
   );

   logic [1:0] pck_css_reg [PCK_COUNT];
   logic [2:0] pck_clock_prescaler_reg [PCK_COUNT];
   logic [PCK_COUNT-1:0] pck_ready;
   logic [PCK_COUNT-1:0] pck_src;
   for (genvar i = 0; i < PCK_COUNT; i++)
   begin : g_pck
      wire w_cfg = wr_stb & (waddr_reg == ADDR_PCK0 + 8'(4 * i));
      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            pck_css_reg[i] <= RST_CSS;
            pck_clock_prescaler_reg[i] <= RST_CLOCK_PRESCALER;
         end
         else if (w_cfg)
         begin
            pck_css_reg[i] <= hwdata[1:0];
            pck_clock_prescaler_reg[i] <= hwdata[CFG_CLOCK_PRESCALER +: 3];
         end
      end
      // no glitch guard: software stops the output around changes
      assign pck_src[i] = pick(pck_css_reg[i], slow_lvl, main_lvl,
         pll_lvl);
      pcm_prescaler u_pck (
         .hclk(hclk),
         .hresetn(hresetn),
         .src_level(pck_src[i]),
         .clock_prescaler(pck_clock_prescaler_reg[i]),
         .enable(pck_en_reg[i]),
         .load(w_cfg),
         .clk_out(programmable_clock_output[i]),
         .ready(pck_ready[i])
      );
   end

   // ----------------------------------------
   // peripheral clocks
   // ----------------------------------------
   logic [PERIPH_COUNT-1:0] periph_en_reg;
   wire [PERIPH_COUNT-1:0] pc_set = hwdata[PERIPH_COUNT-1:0];
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         periph_en_reg <= '0;
      else if (w_pc_en)
         periph_en_reg <= periph_en_reg | pc_set;
      else if (w_pc_dis)
         periph_en_reg <= periph_en_reg & ~pc_set;
   end
   assign peripheral_clock_enable = periph_en_reg;

   // ----------------------------------------
   // status, interrupt and read mux
   // ----------------------------------------
   logic [31:0] status;
   logic [31:0] sc_status;
   logic [31:0] irq_mask_reg;
   always_comb
   begin
      status = 32'h0000_0000;
      status[SR_OSC] = osc_stable_reg;
      status[SR_LOCK] = lock_reg;
      status[SR_MCK] = mck_ready;
      status[SR_PCK0 +: PCK_COUNT] = pck_ready;
      sc_status = 32'h0000_0000;
      sc_status[SC_PROC] = proc_en_reg;
      sc_status[SC_USB] = usb_en_reg;
      sc_status[SC_PCK0 +: PCK_COUNT] = pck_en_reg;
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_mask_reg <= 32'h0000_0000;
      else if (w_irq_en)
         irq_mask_reg <= irq_mask_reg | hwdata;
      else if (w_irq_dis)
         irq_mask_reg <= irq_mask_reg & ~hwdata;
   end
   assign clock_irq = |(status & irq_mask_reg);

   wire [7:0] ra = haddr[7:0];
   wire [31:0] mor_word = {16'h0000, osc_cnt_reg, 6'h00,
      bypass_reg, mosc_en_reg};
   wire [31:0] pll_word = {2'h0, usb_div_reg, 1'b0, mul_reg,
      out_rng_reg, lock_cnt_reg, div_reg};
   wire [31:0] mfr_word = {15'h0000, meas_ready, meas_count};
   wire [1:0] pk = ra[3:2];
   wire pk_ok = (ra[7:4] == ADDR_PCK0[7:4]) & (pk < 2'(PCK_COUNT));
   wire [31:0] pck_word = pk_ok ?
      {27'h0, pck_clock_prescaler_reg[pk], pck_css_reg[pk]} : 32'h0;
   wire [31:0] periph_word = 32'(periph_en_reg);
   assign rmux = (ra == ADDR_SC_STAT) ? sc_status :
      (ra == ADDR_PC_STAT) ? periph_word :
      (ra == ADDR_MOR) ? mor_word :
      (ra == ADDR_MFR) ? mfr_word :
      (ra == ADDR_PLL) ? pll_word :
      (ra == ADDR_MCK) ? {27'h0, mck_clock_prescaler_reg, mck_css_reg} :
      (ra == ADDR_SR) ? status :
      (ra == ADDR_IRQ_MASK) ? irq_mask_reg : pck_word;
endmodule

// ==== testbench/pcm_top_chk.sv ====
// port checker for the power and clock manager
// assumes it is bound onto pcm_top
`timescale 1ns/1ns
module pcm_top_chk
   import pcm_pkg::*;
#(
   parameter int PERIPH_COUNT = 32
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic wake_fast_irq,
   input wire logic wake_normal_irq,
   input wire logic instruction_done,
   input wire logic main_oscillator_enable,
   input wire logic [7:0] pll_divider,
   input wire logic [10:0] pll_multiplier,
   input wire logic pll_enable,
   input wire logic processor_clock_enable,
   input wire logic [PERIPH_COUNT-1:0] peripheral_clock_enable
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic wr_take = hsel && htrans[1] && hwrite;
   pll_power_a: assert property (pll_enable == (pll_multiplier != '0))
      else $error("pll enable disagrees with multiplier");
   reset_state_a: assert property (!$past(hresetn) |->
      !main_oscillator_enable && processor_clock_enable && pll_divider == '0)
      else $error("bad state after reset");
   wake_proc_a: assert property (wake_fast_irq || wake_normal_irq
      |-> ##[1:2] processor_clock_enable) else $error("no wake");
   stop_after_a: assert property ($fell(processor_clock_enable)
      |-> $past(instruction_done)) else $error("stop mid instruction");
   periph_write_a: assert property ($changed(peripheral_clock_enable)
      |-> $past(wr_take, 2)) else $error("peripheral gate moved alone");
   osc_write_a: assert property ($changed(main_oscillator_enable)
      |-> $past(wr_take, 2)) else $error("oscillator moved alone");
   div_write_a: assert property ($changed(pll_divider)
      |-> $past(wr_take, 2)) else $error("divider moved alone");
   mul_write_a: assert property ($changed(pll_multiplier)
      |-> $past(wr_take, 2)) else $error("multiplier moved alone");
   cover property ($fell(processor_clock_enable));
   cover property ($rose(main_oscillator_enable));
   cover property ($rose(pll_enable));
endmodule
bind pcm_top pcm_top_chk #(.PERIPH_COUNT(PERIPH_COUNT)) u_pcm_top_chk (.*);

// ==== testbench/pcm_far_side.sv ====
// clock pins and processor core facing the clock manager
// assumes a 100 ns bus clock; each pin level lasts over 3 bus cycles
`timescale 1ns/1ns
module pcm_far_side
(
   input wire logic hclk,
   output logic slow_clock,
   output logic main_clock,
   output logic pll_clock,
   output logic instruction_done
);
   logic [1:0] step_reg;
   initial
   begin
      slow_clock = 1'b0;
      main_clock = 1'b0;
      pll_clock = 1'b0;
      instruction_done = 1'b0;
      step_reg = 2'h0;
   end
   always #800 slow_clock = ~slow_clock;
   always #400 main_clock = ~main_clock;
   always #350 pll_clock = ~pll_clock;
   // core ends one instruction every fourth cycle, so stops wait a while
   always @(posedge hclk)
   begin
      step_reg <= step_reg + 2'h1;
      instruction_done <= (step_reg == 2'h3);
   end
endmodule

// ==== testbench/pll_and_power_clock_manager_test.sv ====
// self-checking bench for the power and clock manager
// assumes pcm_far_side drives the clock pins and the core signal
`timescale 1ns/1ns
module pll_and_power_clock_manager_test;
   import pcm_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, sc_m, pc_m, d;
   logic [1:0] htrans, pll_out_range;
   logic [2:0] hsize, programmable_clock_output;
   logic slow_clock, main_clock, pll_clock, instruction_done;
   logic wake_fast_irq, wake_normal_irq, main_oscillator_enable;
   logic oscillator_bypass, pll_enable, master_clock, clock_irq;
   logic processor_clock_enable, usb_device_clock;
   logic [7:0] pll_divider;
   logic [10:0] pll_multiplier;
   logic [31:0] peripheral_clock_enable;
   int n_errors, cmp_count, seed, n, k;
   assign hready = hreadyout;
   always #50 hclk = ~hclk;
   pcm_top u_pcm_top (.*);
   pcm_far_side u_pcm_far_side (.*);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
      hwrite <= w;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      d = hrdata;
      if (w && a == ADDR_SC_EN)
         sc_m = sc_m | (wd & 32'h781);
      if (w && a == ADDR_SC_DIS)
         sc_m = sc_m & ~wd;
      if (w && a == ADDR_PC_EN)
         pc_m = pc_m | wd;
      if (w && a == ADDR_PC_DIS)
         pc_m = pc_m & ~wd;
   endtask
   // polls a status bit; the caller judges the final read
   task automatic wait_bit(input logic [7:0] a, input int b);
      int i;
      i = 0;
      xfer(1'b0, a, 32'h0);
      while (d[b] !== 1'b1 && i < 500)
      begin
         xfer(1'b0, a, 32'h0);
         i++;
      end
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // the whole run needs under 1000 cycles
   initial
   begin
      #(30000 * 100);
      n_errors++;
      test_done;
   end
   initial
   begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b1;
      hsize = 3'h2;
      hwrite = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwdata = 32'h0;
      wake_fast_irq = 1'b0;
      wake_normal_irq = 1'b0;
      seed = 32'h349b;
      sc_m = 32'h1;
      pc_m = 32'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, ADDR_SC_STAT, 32'h0);
      check(d, sc_m);
      xfer(1'b0, ADDR_MOR, 32'h0);
      check(d, 32'h0);
      xfer(1'b0, ADDR_PLL, 32'h0);
      check(d, 32'h0);
      xfer(1'b0, 8'h7c, 32'h0);
      check(d, 32'h0);
      $display("reset test done");
      repeat (4)
      begin
         xfer(1'b1, ADDR_PC_EN, $random(seed));
         xfer(1'b1, ADDR_PC_DIS, $random(seed));
         xfer(1'b0, ADDR_PC_STAT, 32'h0);
         check(d, pc_m);
         check(peripheral_clock_enable, pc_m);
      end
      xfer(1'b1, ADDR_PCK0, 32'h0);
      xfer(1'b1, ADDR_SC_EN, 32'h180);
      wait_bit(ADDR_SR, SR_PCK0);
      check(32'(d[SR_PCK0]), 32'h1);
      xfer(1'b1, ADDR_SC_DIS, 32'h80);
      xfer(1'b0, ADDR_SC_STAT, 32'h0);
      check(d, sc_m);
      $display("gating test done");
      xfer(1'b1, ADDR_MCK, {30'h0, CSS_PLL});
      xfer(1'b0, ADDR_SR, 32'h0);
      check(32'(d[SR_MCK]), 32'h0);
      xfer(1'b1, ADDR_PLL, 32'h0002_0201);
      xfer(1'b0, ADDR_SR, 32'h0);
      check(32'(d[SR_LOCK]), 32'h0);
      check(32'({pll_enable, pll_multiplier, pll_divider}), 32'h80201);
      wait_bit(ADDR_SR, SR_LOCK);
      check(32'(d[SR_LOCK]), 32'h1);
      wait_bit(ADDR_SR, SR_MCK);
      check(32'(d[SR_MCK]), 32'h1);
      xfer(1'b1, ADDR_PLL, 32'h0);
      @(posedge hclk);
      check(32'(pll_enable), 32'h0);
      $display("pll test done");
      xfer(1'b1, ADDR_MOR, 32'h0000_0201);
      xfer(1'b0, ADDR_SR, 32'h0);
      check(32'(d[SR_OSC]), 32'h0);
      wait_bit(ADDR_SR, SR_OSC);
      check(32'(d[SR_OSC]), 32'h1);
      wait_bit(ADDR_MFR, MFR_RDY);
      check(32'(d[MFR_RDY]), 32'h1);
      check(32'(d[15:0] > 16'd29 && d[15:0] < 16'd34), 32'h1);
      xfer(1'b1, ADDR_IRQ_EN, 32'h1);
      @(posedge hclk);
      check(32'(clock_irq), 32'h1);
      xfer(1'b1, ADDR_IRQ_DIS, 32'h1);
      @(posedge hclk);
      check(32'(clock_irq), 32'h0);
      xfer(1'b1, ADDR_MOR, 32'h2);
      @(posedge hclk);
      check(32'({oscillator_bypass, main_oscillator_enable}), 32'h2);
      $display("oscillator test done");
      for (k = 0; k < 2; k++)
      begin
         xfer(1'b1, ADDR_SC_DIS, 32'h1);
         n = 0;
         while (processor_clock_enable !== 1'b0 && n < 50)
         begin
            @(posedge hclk);
            n++;
         end
         xfer(1'b0, ADDR_SC_STAT, 32'h0);
         check(32'(d[SC_PROC]), 32'h0);
         wake_fast_irq <= (k == 0);
         wake_normal_irq <= (k == 1);
         @(posedge hclk);
         wake_fast_irq <= 1'b0;
         wake_normal_irq <= 1'b0;
         repeat (2) @(posedge hclk);
         check(32'(processor_clock_enable), 32'h1);
      end
      $display("idle test done");
      test_done;
   end
endmodule
